// ### core/mqwps_top.sv
module mqwps_top (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Straps and modes
  input  wire logic [mqwps_pkg::DEV_W-1:0]   device_id_strap,
  input  wire logic                          flag_mode_polled,
  input  wire logic                          serial_program_done,
  // Write port
  input  wire logic                          write_queue_addr_strobe,
  input  wire logic [mqwps_pkg::ADDR_W-1:0]  write_queue_addr_bus,
  input  wire logic                          flag_device_strobe,
  input  wire logic                          write_en_n,
  input  wire logic [mqwps_pkg::DATA_W-1:0]  din,
  // Flag outputs
  output logic [mqwps_pkg::NUM_Q-1:0]        almost_full_flag_bus_n,
  output logic                               almost_full_flag_oe,
  output logic                               full_flag_out_n,
  output logic                               flag_bus_sync,
  // Expansion
  input  wire logic                          expansion_token_in,
  output logic                               expansion_token_out,
  // Drain port
  input  wire logic                          rd_en,
  input  wire logic [mqwps_pkg::QSEL_W-1:0]  rd_queue,
  output logic [mqwps_pkg::DATA_W-1:0]       rd_data,
  output logic                               rd_valid
);
  import mqwps_pkg::*;

  logic [DEV_W-1:0]               dev_id_q;
  mqwps_sel_e                     state_q;
  logic [QSEL_W-1:0]              pend_qsel_q;
  logic                           pend_hit_q;
  logic [QSEL_W-1:0]              cur_qsel_q;
  logic                           cur_sel_q;
  logic [DEV_W-1:0]               flag_dev_q;
  logic [DEV_W-1:0]               poll_ptr_q;
  logic [QSEL_W-1:0]              addr_qsel;
  logic [DEV_W-1:0]               addr_dev;
  logic                           addr_match;
  logic                           sel_take;
  logic                           flag_take;
  logic                           wr_fire;
  logic                           skid_ready;
  logic                           buf_valid;
  logic                           buf_ready;
  logic [ENTRY_W-1:0]             buf_data;
  logic [NUM_Q-1:0][CNT_W-1:0]    q_count;
  logic [NUM_Q-1:0]               af_vec;
  logic [NUM_Q-1:0]               full_vec;
  logic                           own_slot;

  // Address fields
  assign addr_qsel  = write_queue_addr_bus[QSEL_LSB +: QSEL_W];
  assign addr_dev   = write_queue_addr_bus[DEV_LSB +: DEV_W];
  assign addr_match = (addr_dev == dev_id_q);

  // Queue selection is blocked while programming is in progress, flag selection in polled mode
  assign sel_take  = write_queue_addr_strobe & ~serial_program_done;
  assign flag_take = flag_device_strobe & ~flag_mode_polled;

  // Device ID strap caught while reset is held
  always_ff @(posedge clk) begin
    if (rst) begin
      dev_id_q <= device_id_strap;
    end
  end

  // Selection pipeline state
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= MQWPS_SEL_IDLE;
    end else begin
      case (state_q)
        MQWPS_SEL_IDLE: begin
          state_q <= sel_take ? MQWPS_SEL_PEND : MQWPS_SEL_IDLE;
        end
        MQWPS_SEL_PEND: begin
          state_q <= sel_take ? MQWPS_SEL_PEND : MQWPS_SEL_IDLE;
        end
        default: begin
          state_q <= MQWPS_SEL_IDLE;
        end
      endcase
    end
  end

  // Pending selection from the selecting edge
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_qsel_q <= QSEL_RST;
      pend_hit_q  <= 1'b0;
    end else if (sel_take) begin
      pend_qsel_q <= addr_qsel;
      pend_hit_q  <= addr_match;
    end
  end

  // Active write queue, updated one edge after selection
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_qsel_q <= QSEL_RST;
      cur_sel_q  <= 1'b0;
    end else if (state_q == MQWPS_SEL_PEND) begin
      cur_qsel_q <= pend_qsel_q;
      cur_sel_q  <= pend_hit_q;
    end
  end

  // Write into buffer path
  assign wr_fire = ~write_en_n & cur_sel_q;

  mqwps_skid #(
    .W (ENTRY_W)
  ) u_skid (
    .clk     (clk),
    .rst     (rst),
    .s_valid (wr_fire),
    .s_ready (skid_ready),
    .s_data  ({cur_qsel_q, din}),
    .m_valid (buf_valid),
    .m_ready (buf_ready),
    .m_data  (buf_data)
  );

  mqwps_mem u_mem (
    .clk      (clk),
    .rst      (rst),
    .wr_valid (buf_valid),
    .wr_ready (buf_ready),
    .wr_queue (buf_data[ENTRY_W-1 -: QSEL_W]),
    .wr_data  (buf_data[DATA_W-1:0]),
    .rd_en    (rd_en),
    .rd_queue (rd_queue),
    .rd_data  (rd_data),
    .rd_valid (rd_valid),
    .q_count  (q_count)
  );

  // Per-queue level flags
  genvar i;
  generate
    for (i = 0; i < NUM_Q; i++) begin : g_flags
      assign af_vec[i]   = (q_count[i] >= AF_LEVEL);
      assign full_vec[i] = (q_count[i] == FULL_LVL);
    end
  endgenerate

  // Full flag for the active queue, also when buffer stalls
  always_ff @(posedge clk) begin
    if (rst) begin
      full_flag_out_n <= 1'b1;
    end else begin
      full_flag_out_n <= ~(cur_sel_q & (full_vec[cur_qsel_q] | ~skid_ready));
    end
  end

  // Direct mode flag device select
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_dev_q <= DEV_RST;
    end else if (flag_take) begin
      flag_dev_q <= addr_dev;
    end
  end

  // Polled mode device slot counter, realigned by the token
  always_ff @(posedge clk) begin
    if (rst) begin
      poll_ptr_q <= DEV_RST;
    end else if (!flag_mode_polled) begin
      poll_ptr_q <= DEV_RST;
    end else if (expansion_token_in) begin
      poll_ptr_q <= dev_id_q;
    end else begin
      poll_ptr_q <= poll_ptr_q + 3'h1;
    end
  end

  assign own_slot = flag_mode_polled ? (poll_ptr_q == dev_id_q) : (flag_dev_q == dev_id_q);

  // Registered flag bus and expansion outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      almost_full_flag_bus_n <= '1;
      almost_full_flag_oe    <= 1'b0;
      flag_bus_sync          <= 1'b0;
      expansion_token_out    <= 1'b0;
    end else begin
      almost_full_flag_bus_n <= ~af_vec;
      almost_full_flag_oe    <= own_slot;
      flag_bus_sync          <= flag_mode_polled & (poll_ptr_q == DEV_RST);
      expansion_token_out    <= flag_mode_polled & own_slot;
    end
  end

  // Checks
  a_sel_latency: assert property (@(posedge clk) disable iff (rst)
    (sel_take && addr_match) |-> ##2 (cur_sel_q && cur_qsel_q == $past(addr_qsel, 2)))
    else $error("new queue not active two edges after selection");

  a_old_queue_hold: assert property (@(posedge clk) disable iff (rst)
    (sel_take && state_q == MQWPS_SEL_IDLE) |=> ($stable(cur_qsel_q) && $stable(cur_sel_q)))
    else $error("queue changed too early after selection");

  a_mismatch_desel: assert property (@(posedge clk) disable iff (rst)
    (sel_take && !addr_match) |-> ##2 !cur_sel_q)
    else $error("device stayed selected with foreign id");

  a_unsel_ignore: assert property (@(posedge clk) disable iff (rst)
    (!cur_sel_q && !buf_valid) |=> !buf_valid)
    else $error("write accepted while not selected");

  a_write_store: assert property (@(posedge clk) disable iff (rst)
    (!write_en_n && cur_sel_q && skid_ready) |=> buf_valid)
    else $error("enabled write not buffered");

  a_wen_free_sel: assert property (@(posedge clk) disable iff (rst)
    (sel_take && write_en_n) |=> state_q == MQWPS_SEL_PEND)
    else $error("selection lost with write enable high");

  a_prog_block: assert property (@(posedge clk) disable iff (rst)
    (serial_program_done && state_q == MQWPS_SEL_IDLE) |=> state_q == MQWPS_SEL_IDLE)
    else $error("selection taken during programming");

  a_flag_direct: assert property (@(posedge clk) disable iff (rst)
    (flag_take && addr_dev == dev_id_q) ##1 !flag_mode_polled |=> almost_full_flag_oe)
    else $error("flag bus not driven after device strobe");

  a_poll_sync: assert property (@(posedge clk) disable iff (rst)
    (flag_mode_polled && poll_ptr_q == DEV_RST) |=> flag_bus_sync)
    else $error("sync marker missing in polled mode");

  a_token_align: assert property (@(posedge clk) disable iff (rst)
    (flag_mode_polled && expansion_token_in) |=> (poll_ptr_q == dev_id_q || !flag_mode_polled))
    else $error("token did not realign slot counter");

  a_full_stall: assert property (@(posedge clk) disable iff (rst)
    (cur_sel_q && !skid_ready) |=> !full_flag_out_n)
    else $error("full flag not raised on stall");

  a_addr_latch: assert property (@(posedge clk) disable iff (rst)
    sel_take |=> (pend_qsel_q == $past(addr_qsel)))
    else $error("queue address not latched on strobe");

  a_id_latch: assert property (@(posedge clk) disable iff (rst)
    sel_take |=> (pend_hit_q == $past(addr_match)))
    else $error("device match not latched on strobe");

  a_sel_keep_idle: assert property (@(posedge clk) disable iff (rst)
    (!sel_take && state_q == MQWPS_SEL_IDLE) |=> ($stable(cur_qsel_q) && $stable(cur_sel_q)))
    else $error("write queue changed without selection");

  a_unsel_full_high: assert property (@(posedge clk) disable iff (rst)
    !cur_sel_q |=> full_flag_out_n)
    else $error("full flag low while not selected");

  a_full_level: assert property (@(posedge clk) disable iff (rst)
    (cur_sel_q && full_vec[cur_qsel_q]) |=> !full_flag_out_n)
    else $error("full flag missing at full queue");

  a_af_bus_reg: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> (almost_full_flag_bus_n == ~$past(af_vec)))
    else $error("almost full bus not registered");

  a_flag_capture: assert property (@(posedge clk) disable iff (rst)
    flag_take |=> (flag_dev_q == $past(addr_dev)))
    else $error("flag device not captured");

  a_flag_other: assert property (@(posedge clk) disable iff (rst)
    (!flag_mode_polled && flag_dev_q != dev_id_q) |=> !almost_full_flag_oe)
    else $error("flag bus driven for other device");

  a_poll_step: assert property (@(posedge clk) disable iff (rst)
    (flag_mode_polled && !expansion_token_in) |=> (poll_ptr_q == $past(poll_ptr_q) + 3'h1))
    else $error("slot counter did not step");

  a_sync_only_zero: assert property (@(posedge clk) disable iff (rst)
    (!flag_mode_polled || poll_ptr_q != DEV_RST) |=> !flag_bus_sync)
    else $error("sync marker outside slot zero");

  a_token_own: assert property (@(posedge clk) disable iff (rst)
    (flag_mode_polled && poll_ptr_q == dev_id_q) |=> expansion_token_out)
    else $error("token out missing in own slot");

  a_token_direct: assert property (@(posedge clk) disable iff (rst)
    !flag_mode_polled |=> !expansion_token_out)
    else $error("token out in direct mode");
endmodule // mqwps_top

// ### include/mqwps_pkg.sv
package mqwps_pkg;
  // Widths and counts
  localparam int DATA_W        = 36;
  localparam int ADDR_W        = 5;
  localparam int QSEL_W        = 2;
  localparam int DEV_W         = 3;
  localparam int NUM_Q         = 4;
  localparam int NUM_DEV       = 8;
  localparam int QSEL_LSB      = 0;
  localparam int DEV_LSB       = 2;
  localparam int ENTRY_W       = DATA_W + QSEL_W;

  // Queue storage
  localparam int QDEPTH        = 16;
  localparam int PTR_W         = 4;
  localparam int CNT_W         = 5;
  localparam logic [CNT_W-1:0] AF_LEVEL  = 5'h0c;
  localparam logic [CNT_W-1:0] FULL_LVL  = 5'h10;

  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int SEL_LATENCY   = 2;

  // Reset values
  localparam logic [QSEL_W-1:0] QSEL_RST = 2'h0;
  localparam logic [DEV_W-1:0]  DEV_RST  = 3'h0;

  // Queue selection pipeline
  typedef enum logic [0:0] {
    MQWPS_SEL_IDLE = 1'b0,
    MQWPS_SEL_PEND = 1'b1
  } mqwps_sel_e;
endpackage

// ### core/mqwps_skid.sv
module mqwps_skid #(
  parameter int W = mqwps_pkg::ENTRY_W
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Filling side
  input  wire logic         s_valid,
  output logic              s_ready,
  input  wire logic [W-1:0] s_data,
  // Draining side
  output logic              m_valid,
  input  wire logic         m_ready,
  output logic [W-1:0]      m_data
);
  import mqwps_pkg::*;

  logic [W-1:0] slot_q [2];
  logic         wp_q;
  logic         rp_q;
  logic [1:0]   cnt_q;
  logic         push;
  logic         pop;

  assign s_ready = (cnt_q != 2'h2);
  assign m_valid = (cnt_q != 2'h0);
  assign m_data  = slot_q[rp_q];
  assign push    = s_valid & s_ready;
  assign pop     = m_valid & m_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      slot_q[wp_q] <= s_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + 2'(push) - 2'(pop);
    end
  end
endmodule // mqwps_skid

// ### core/mqwps_mem.sv
module mqwps_mem (
  // Clock and reset
  input  wire logic                             clk,
  input  wire logic                             rst,
  // Write side
  input  wire logic                             wr_valid,
  output logic                                  wr_ready,
  input  wire logic [mqwps_pkg::QSEL_W-1:0]     wr_queue,
  input  wire logic [mqwps_pkg::DATA_W-1:0]     wr_data,
  // Drain side
  input  wire logic                             rd_en,
  input  wire logic [mqwps_pkg::QSEL_W-1:0]     rd_queue,
  output logic [mqwps_pkg::DATA_W-1:0]          rd_data,
  output logic                                  rd_valid,
  // Occupancy
  output logic [mqwps_pkg::NUM_Q-1:0][mqwps_pkg::CNT_W-1:0] q_count
);
  import mqwps_pkg::*;

  logic [DATA_W-1:0]           store_q [NUM_Q*QDEPTH];
  logic [NUM_Q-1:0][PTR_W-1:0] wptr_q;
  logic [NUM_Q-1:0][PTR_W-1:0] rptr_q;
  logic [NUM_Q-1:0][CNT_W-1:0] cnt_q;
  logic                        wr_do;
  logic                        rd_do;

  assign q_count  = cnt_q;
  assign wr_ready = (cnt_q[wr_queue] != FULL_LVL);
  assign wr_do    = wr_valid & wr_ready;
  assign rd_do    = rd_en & (cnt_q[rd_queue] != '0);

  genvar i;
  generate
    for (i = 0; i < NUM_Q; i++) begin : g_queue
      logic inc;
      logic dec;
      assign inc = wr_do & (wr_queue == QSEL_W'(i));
      assign dec = rd_do & (rd_queue == QSEL_W'(i));
      always_ff @(posedge clk) begin
        if (rst) begin
          wptr_q[i] <= '0;
          rptr_q[i] <= '0;
          cnt_q[i]  <= '0;
        end else begin
          wptr_q[i] <= wptr_q[i] + PTR_W'(inc);
          rptr_q[i] <= rptr_q[i] + PTR_W'(dec);
          cnt_q[i]  <= cnt_q[i] + CNT_W'(inc) - CNT_W'(dec);
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (wr_do) begin
      store_q[{wr_queue, wptr_q[wr_queue]}] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data  <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_do;
      if (rd_do) begin
        rd_data <= store_q[{rd_queue, rptr_q[rd_queue]}];
      end
    end
  end
endmodule // mqwps_mem

// ### bench/mqwps_drain_model.sv
module mqwps_drain_model (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // Requests from the bench
  input  wire logic                         go,
  input  wire logic                         stall,
  input  wire logic [mqwps_pkg::QSEL_W-1:0] req_q,
  input  wire logic [4:0]                   req_n,
  // Drain port
  output logic                              rd_en,
  output logic [mqwps_pkg::QSEL_W-1:0]      rd_queue,
  output logic                              busy
);
  timeunit 1ns;
  timeprecision 1ps;
  import mqwps_pkg::*;
  logic [4:0] left_q;
  // Issues req_n reads, pausing whenever stall is high
  always_ff @(posedge clk) begin
    if (rst) begin
      left_q <= 5'h00;
      rd_en  <= 1'b0;
    end else if (go) begin
      left_q   <= req_n;
      rd_queue <= req_q;
      rd_en    <= 1'b0;
    end else if (left_q != 5'h00 && !stall) begin
      left_q <= left_q - 5'h01;
      rd_en  <= 1'b1;
    end else begin
      rd_en <= 1'b0;
    end
  end
  assign busy = (left_q != 5'h00) || rd_en;
endmodule // mqwps_drain_model

// ### bench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mqwps_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [DEV_W-1:0] id = 3'h5;
  logic polled = 1'b0, spd = 1'b1, ws = 1'b0, fs = 1'b0, wen_n = 1'b1, tok_in = 1'b0;
  logic [ADDR_W-1:0] addr = 5'h00;
  logic [DATA_W-1:0] din = 36'h0, rd_data, d;
  logic [NUM_Q-1:0] af_n;
  logic oe, full_n, sync, tok_out, rd_en, rd_valid, busy;
  logic go = 1'b0, stall = 1'b0;
  logic [QSEL_W-1:0] rq = 2'h0, rd_queue;
  logic [4:0] rn = 5'h00;
  logic [DATA_W-1:0] exp_q[$];
  int err_total = 0, comparisons = 0, k, n_s, n_t;

  always #4 clk = ~clk;

  mqwps_top mqwps_top_inst (.clk(clk), .rst(rst), .device_id_strap(id), .flag_mode_polled(polled),
    .serial_program_done(spd), .write_queue_addr_strobe(ws), .write_queue_addr_bus(addr),
    .flag_device_strobe(fs), .write_en_n(wen_n), .din(din), .almost_full_flag_bus_n(af_n),
    .almost_full_flag_oe(oe), .full_flag_out_n(full_n), .flag_bus_sync(sync),
    .expansion_token_in(tok_in), .expansion_token_out(tok_out), .rd_en(rd_en),
    .rd_queue(rd_queue), .rd_data(rd_data), .rd_valid(rd_valid));
  mqwps_drain_model mqwps_drain_model_inst (.clk(clk), .rst(rst), .go(go), .stall(stall), .req_q(rq),
    .req_n(rn), .rd_en(rd_en), .rd_queue(rd_queue), .busy(busy));

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] want, input string m);
    comparisons++;
    if (got !== want) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task automatic results();
    $display("checks %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One write-port cycle: strobe, address, enable and data for one edge
  task automatic wr(input logic s, input logic [ADDR_W-1:0] a, input logic e, input logic [DATA_W-1:0] v);
    ws <= s;
    addr <= a;
    wen_n <= e;
    din <= v;
    @(posedge clk);
  endtask

  // Drains up to n words of queue q with random stalls, bounded wait
  task automatic drain(input logic [QSEL_W-1:0] q, input logic [4:0] n);
    rq <= q;
    rn <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    for (k = 0; k < 300 && busy; k++) begin
      stall <= 1'($urandom_range(1));
      @(posedge clk);
    end
    stall <= 1'b0;
    repeat (3) @(posedge clk);
    if (busy || exp_q.size() != 0) begin
      err_total++;
      $display("wrong value at %0t: drain did not finish", $time);
      results();
    end
  endtask

  // Result watcher
  always @(negedge clk) begin
    if (!rst && rd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(1'b1, 1'b0, "unexpected word");
      else chk(rd_data, exp_q.pop_front(), "drained word");
    end
  end

  initial begin
    void'($urandom(32'h0b02449b));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk({af_n, oe, full_n, sync, tok_out}, 8'hf4, "reset outputs");
    // Programming still running just after reset
    repeat (2) @(posedge clk);
    spd <= 1'b0;
    @(posedge clk);
    // Select timing: old queue on selecting edge and next
    wr(1'b1, {id, 2'h1}, 1'b0, 36'h0aa);
    wr(1'b0, 5'h00, 1'b0, 36'h0bb);
    for (int i = 0; i < 5; i++) begin
      d = {$urandom, 4'h1};
      wr(i == 2, {id, 2'h2}, 1'b0, d);
      if (i < 4) exp_q.push_back(d);
    end
    wr(1'b1, {id, 2'h0}, 1'b1, 36'h0cc);
    wr(1'b0, 5'h00, 1'b1, 36'h0dd);
    wr(1'b0, 5'h00, 1'b0, 36'h123);
    wr(1'b0, 5'h00, 1'b1, 36'h0);
    repeat (4) @(posedge clk);
    drain(2'h1, 5'h06);
    exp_q.push_back(d);
    drain(2'h2, 5'h02);
    exp_q.push_back(36'h123);
    drain(2'h0, 5'h02);
    $display("test select_timing done");
    // Other device selected: first write still goes to queue 0, later writes ignored until reselect
    wr(1'b1, {3'h2, 2'h1}, 1'b1, 36'h0);
    for (int i = 0; i < 4; i++) wr(1'b0, 5'h00, 1'b0, 36'h0ee);
    wr(1'b1, {id, 2'h1}, 1'b1, 36'h0);
    wr(1'b0, 5'h00, 1'b1, 36'h0);
    wr(1'b0, 5'h00, 1'b0, 36'h456);
    exp_q.push_back(36'h456);
    wr(1'b0, 5'h00, 1'b1, 36'h0);
    repeat (4) @(posedge clk);
    drain(2'h1, 5'h04);
    $display("test id_mismatch done");
    // Fill queue 3 to full
    wr(1'b1, {id, 2'h3}, 1'b1, 36'h0);
    wr(1'b0, 5'h00, 1'b1, 36'h0);
    for (int i = 0; i < QDEPTH; i++) begin
      d = {$urandom, 4'h3};
      wr(1'b0, 5'h00, 1'b0, d);
      exp_q.push_back(d);
    end
    wr(1'b0, 5'h00, 1'b1, 36'h0);
    repeat (5) @(posedge clk);
    chk({af_n[3], full_n}, 2'h0, "flags at full");
    drain(2'h3, 5'h10);
    chk({af_n[3], full_n}, 2'h3, "flags after drain");
    $display("test fill_drain done");
    // Polled flags step without write enable
    polled <= 1'b1;
    repeat (10) @(posedge clk);
    n_s = 0;
    n_t = 0;
    for (int i = 0; i < 32; i++) begin
      @(negedge clk);
      n_s += int'(sync === 1'b1);
      n_t += int'(tok_out === 1'b1);
    end
    chk(n_s, 4, "sync count");
    chk(n_t, 4, "token count");
    // Token held two edges pins the slot counter to the own id
    @(posedge clk);
    tok_in <= 1'b1;
    repeat (2) @(posedge clk);
    tok_in <= 1'b0;
    @(negedge clk);
    chk(tok_out, 1'b1, "token realign first");
    @(negedge clk);
    chk(tok_out, 1'b1, "token realign second");
    @(posedge clk);
    polled <= 1'b0;
    repeat (10) @(posedge clk);
    $display("test polled done");
    // Direct mode flag device select, low bits ignored
    fs <= 1'b1;
    addr <= {id, 2'h3};
    @(posedge clk);
    fs <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(oe, 1'b1, "own flag device");
    @(posedge clk);
    fs <= 1'b1;
    addr <= {3'h1, 2'h0};
    @(posedge clk);
    fs <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(oe, 1'b0, "other flag device");
    $display("test flag_direct done");
    results();
  end
endmodule // tb_top
